// *** ttlp_pkg.sv ***
// Constants and types shared by the two-tap line pixel output block
`default_nettype none
package ttlp_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_MHZ = 10;
  localparam int unsigned DLY40_NS = 2650;
  localparam int unsigned DLY40_BIN_NS = 3250;
  localparam int unsigned DLY40_BIN_EDGE_NS = 3300;
  localparam int unsigned DLY80_NS = 2850;
  localparam int unsigned DLY80_EDGE_NS = 2900;
  localparam int unsigned DLY80_BIN_NS = 9500;
  localparam int unsigned DLY80_BIN_EDGE_NS = 9850;
  // Nearest whole cycle keeps every delay inside its band
  localparam logic [7:0] DLY40_CYC = 8'((DLY40_NS * CLK_MHZ + 500) / 1000);
  localparam logic [7:0] DLY40_BIN_CYC = 8'((DLY40_BIN_NS * CLK_MHZ + 500) / 1000);
  localparam logic [7:0] DLY40_BIN_EDGE_CYC = 8'((DLY40_BIN_EDGE_NS * CLK_MHZ + 500) / 1000);
  localparam logic [7:0] DLY80_CYC = 8'((DLY80_NS * CLK_MHZ + 500) / 1000);
  localparam logic [7:0] DLY80_EDGE_CYC = 8'((DLY80_EDGE_NS * CLK_MHZ + 500) / 1000);
  localparam logic [7:0] DLY80_BIN_CYC = 8'((DLY80_BIN_NS * CLK_MHZ + 500) / 1000);
  localparam logic [7:0] DLY80_BIN_EDGE_CYC = 8'((DLY80_BIN_EDGE_NS * CLK_MHZ + 500) / 1000);

  // ==========================================================
  // Line lengths in pixels
  localparam logic [12:0] PIX_4K = 13'h1000;
  localparam logic [12:0] PIX_2K = 13'h0800;

  // ==========================================================
  // Register byte offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_REGION = 4'h4;
  localparam logic [3:0] OFS_EXPO = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;

  // ==========================================================
  // Control field positions
  localparam int unsigned CTRL_DEPTH_LSB = 0;
  localparam int unsigned CTRL_BIN = 2;
  localparam int unsigned CTRL_FAST = 3;
  localparam int unsigned CTRL_SINGLE = 4;
  localparam int unsigned CTRL_EXPO_LSB = 5;
  localparam int unsigned CTRL_4K = 7;
  localparam int unsigned CTRL_REGION = 8;
  localparam int unsigned CTRL_EN = 9;
  localparam logic [9:0] CTRL_RST = 10'h002;
  localparam logic [12:0] REGION_RST = 13'h0800;
  localparam logic [15:0] EXPO_RST = 16'h0000;

  // Bit depth encodings
  typedef enum logic [1:0] {
    DEPTH_8 = 2'b00,
    DEPTH_10 = 2'b01,
    DEPTH_12 = 2'b10
  } ttlp_depth_t;

  // Exposure modes
  typedef enum logic [1:0] {
    EXPO_PROG = 2'b00,
    EXPO_EDGE = 2'b01,
    EXPO_LEVEL = 2'b10
  } ttlp_expo_t;

  // Line state machine
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DELAY = 2'b01,
    ST_ALIGN = 2'b10,
    ST_SEND = 2'b11
  } ttlp_state_t;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : ttlp_pkg

`default_nettype wire

// *** ttlp_out.sv ***
// Two-tap line pixel output formatter with AXI4-Lite control
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module ttlp_out (
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins and sensor side
  input wire logic pix_clk,
  input wire logic line_trig,
  input wire logic [11:0] pix_odd,
  input wire logic [11:0] pix_even,
  output logic pix_take,
  output logic [12:0] pix_index,
  output logic [7:0] port_a,
  output logic [7:0] port_b,
  output logic [7:0] port_c,
  output logic line_valid,
  output logic data_valid,
  output logic frame_valid,
  output logic spare,
  output logic tx_strobe,
  output logic pix_clk_fast
);
  import ttlp_pkg::*;

  // ==========================================================
  // Functions

  // Places two converter results on ports A, B, C for a depth
  function automatic logic [23:0] map_ports(input logic [1:0] depth, input logic [11:0] p1,
                                            input logic [11:0] p2);
    logic [23:0] r;
    r = 24'h000000;
    if (depth == DEPTH_12) begin
      r = {p2[7:0], p2[11:8], p1[11:8], p1[7:0]};
    end else if (depth == DEPTH_10) begin
      r = {p2[9:2], 2'b00, p2[11:10], 2'b00, p1[11:10], p1[9:2]};
    end else begin
      r = {8'h00, p2[11:4], p1[11:4]};
    end
    return r;
  endfunction : map_ports

  // Fixed part of the line valid delay in clock cycles
  function automatic logic [7:0] base_delay(input logic fast, input logic bin,
                                            input logic single, input logic [1:0] expo);
    logic edge_single;
    logic [7:0] r;
    edge_single = single && (expo == EXPO_EDGE);
    if (!fast && !bin) begin
      r = DLY40_CYC;
    end else if (!fast) begin
      r = edge_single ? DLY40_BIN_EDGE_CYC : DLY40_BIN_CYC;
    end else if (!bin) begin
      r = edge_single ? DLY80_EDGE_CYC : DLY80_CYC;
    end else begin
      r = edge_single ? DLY80_BIN_EDGE_CYC : DLY80_BIN_CYC;
    end
    return r;
  endfunction : base_delay

  // ==========================================================
  // Registers and state
  logic [9:0] ctrl_q;
  logic [12:0] region_q;
  logic [15:0] expo_q;
  logic [15:0] line_cnt_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [3:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic pclk_m_q;
  logic pclk_s_q;
  logic pclk_p_q;
  logic trig_m_q;
  logic trig_s_q;
  logic trig_p_q;
  ttlp_state_t state_q;
  logic [16:0] dly_q;
  logic [1:0] depth_q;
  logic [11:0] words_q;
  logic [12:0] index_q;
  logic pclk_rise;
  logic trig_rise;
  logic [12:0] line_pix;
  logic do_write;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge clk) begin
    if (rst) begin
      pclk_m_q <= 1'b0;
      pclk_s_q <= 1'b0;
      pclk_p_q <= 1'b0;
      trig_m_q <= 1'b0;
      trig_s_q <= 1'b0;
      trig_p_q <= 1'b0;
    end else begin
      pclk_m_q <= pix_clk;
      pclk_s_q <= pclk_m_q;
      pclk_p_q <= pclk_s_q;
      trig_m_q <= line_trig;
      trig_s_q <= trig_m_q;
      trig_p_q <= trig_s_q;
    end
  end

  // Edge events on the synchronised pins
  assign pclk_rise = pclk_s_q && !pclk_p_q;
  assign trig_rise = trig_s_q && !trig_p_q;

  // ==========================================================
  // AXI4-Lite write path: address and data taken in either order
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
  assign do_write = aw_hold_q && w_hold_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_q == OFS_CTRL || aw_addr_q == OFS_REGION || aw_addr_q == OFS_EXPO) begin
          s_axi_bresp <= RESP_OKAY;
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control registers, byte lanes honoured
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
      region_q <= REGION_RST;
      expo_q <= EXPO_RST;
    end else if (do_write) begin
      if (aw_addr_q == OFS_CTRL) begin
        if (w_strb_q[0]) ctrl_q[7:0] <= w_data_q[7:0];
        if (w_strb_q[1]) ctrl_q[9:8] <= w_data_q[9:8];
      end else if (aw_addr_q == OFS_REGION) begin
        if (w_strb_q[0]) region_q[7:0] <= w_data_q[7:0];
        if (w_strb_q[1]) region_q[12:8] <= w_data_q[12:8];
      end else if (aw_addr_q == OFS_EXPO) begin
        if (w_strb_q[0]) expo_q[7:0] <= w_data_q[7:0];
        if (w_strb_q[1]) expo_q[15:8] <= w_data_q[15:8];
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read path, answer one cycle after the address
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (s_axi_araddr == OFS_CTRL) begin
        s_axi_rdata <= {22'h000000, ctrl_q};
      end else if (s_axi_araddr == OFS_REGION) begin
        s_axi_rdata <= {19'h00000, region_q};
      end else if (s_axi_araddr == OFS_EXPO) begin
        s_axi_rdata <= {16'h0000, expo_q};
      end else if (s_axi_araddr == OFS_STATUS) begin
        s_axi_rdata <= {line_cnt_q, 12'h000, depth_q, line_valid, state_q != ST_IDLE};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Pixels per line from model, binning and region window
  always_comb begin
    if (ctrl_q[CTRL_REGION]) begin
      line_pix = region_q;
    end else begin
      line_pix = ctrl_q[CTRL_4K] ? PIX_4K : PIX_2K;
      if (ctrl_q[CTRL_BIN]) line_pix = {1'b0, line_pix[12:1]};
    end
  end

  // Speed setting drives the pixel clock selector
  assign pix_clk_fast = ctrl_q[CTRL_FAST];

  // ==========================================================
  // Line sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      dly_q <= 17'h00000;
      depth_q <= DEPTH_12;
      words_q <= 12'h000;
      index_q <= 13'h0000;
      line_cnt_q <= 16'h0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (trig_rise && ctrl_q[CTRL_EN] && line_pix != 13'h0000) begin
            state_q <= ST_DELAY;
            depth_q <= ctrl_q[CTRL_DEPTH_LSB +: 2];
            words_q <= 12'(({1'b0, line_pix} + 14'h0001) >> 1);
            dly_q <= {9'h000, base_delay(ctrl_q[CTRL_FAST], ctrl_q[CTRL_BIN], ctrl_q[CTRL_SINGLE],
                                         ctrl_q[CTRL_EXPO_LSB +: 2])}
                     + ((ctrl_q[CTRL_EXPO_LSB +: 2] == EXPO_PROG) ? {1'b0, expo_q} : 17'h00000);
          end
        end
        ST_DELAY: begin
          if (dly_q <= 17'h00001) begin
            state_q <= ST_ALIGN;
          end
          dly_q <= dly_q - 17'h00001;
        end
        ST_ALIGN: begin
          if (pclk_rise) begin
            state_q <= ST_SEND;
            index_q <= 13'h0002;
            words_q <= words_q - 12'h001;
          end
        end
        ST_SEND: begin
          if (pclk_rise) begin
            if (words_q == 12'h000) begin
              state_q <= ST_IDLE;
              line_cnt_q <= line_cnt_q + 16'h0001;
            end else begin
              words_q <= words_q - 12'h001;
              index_q <= index_q + 13'h0002;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Sensor side fetches a pixel pair when a word is launched
  assign pix_take = pclk_rise && (state_q == ST_ALIGN || (state_q == ST_SEND && words_q != 12'h000));
  assign pix_index = (state_q == ST_ALIGN) ? 13'h0000 : index_q;

  // ==========================================================
  // Transmitter X word, launched on pixel clock rising edges only
  always_ff @(posedge clk) begin
    if (rst) begin
      port_a <= 8'h00;
      port_b <= 8'h00;
      port_c <= 8'h00;
      line_valid <= 1'b0;
      data_valid <= 1'b0;
      tx_strobe <= 1'b0;
    end else begin
      tx_strobe <= pclk_s_q;
      if (pclk_rise) begin
        if (pix_take) begin
          {port_c, port_b, port_a} <= map_ports(depth_q, pix_odd, pix_even);
          line_valid <= 1'b1;
          data_valid <= 1'b1;
        end else begin
          {port_c, port_b, port_a} <= 24'h000000;
          line_valid <= 1'b0;
          data_valid <= 1'b0;
        end
      end
    end
  end

  // Frame valid and spare outputs are not used in this format
  assign frame_valid = 1'b0;
  assign spare = 1'b0;

  // ==========================================================
  // Assertions
  property p_flags_together;
    @(posedge clk) disable iff (rst) line_valid == data_valid;
  endproperty
  a_flags_together: assert property (p_flags_together) else $error("valid flags differ");

  property p_launch_on_edge;
    @(posedge clk) disable iff (rst) $changed(line_valid) |-> $past(pclk_rise);
  endproperty
  a_launch_on_edge: assert property (p_launch_on_edge) else $error("flag moved off edge");

  property p_idle_low;
    @(posedge clk) disable iff (rst) state_q != ST_SEND
      |-> !line_valid;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("valid high with no line");

  property p_map12;
    @(posedge clk) disable iff (rst) pix_take && depth_q == DEPTH_12
      |=> port_a == $past(pix_odd[7:0]) && port_c == $past(pix_even[7:0])
          && port_b == {$past(pix_even[11:8]), $past(pix_odd[11:8])};
  endproperty
  a_map12: assert property (p_map12) else $error("twelve bit mapping wrong");

  property p_map10;
    @(posedge clk) disable iff (rst) pix_take && depth_q == DEPTH_10
      |=> port_a == $past(pix_odd[9:2]) && port_b[3:2] == 2'b00 && port_b[7:6] == 2'b00;
  endproperty
  a_map10: assert property (p_map10) else $error("ten bit mapping wrong");

  property p_map8;
    @(posedge clk) disable iff (rst) pix_take && depth_q == DEPTH_8
      |=> port_a == $past(pix_odd[11:4]) && port_b == $past(pix_even[11:4]) && port_c == 8'h00;
  endproperty
  a_map8: assert property (p_map8) else $error("eight bit mapping wrong");

  property p_depth_stable;
    @(posedge clk) disable iff (rst) line_valid && $past(line_valid) |-> $stable(depth_q);
  endproperty
  a_depth_stable: assert property (p_depth_stable) else $error("depth changed in line");

  property p_trig_starts_delay;
    @(posedge clk) disable iff (rst) state_q == ST_IDLE && trig_rise && ctrl_q[CTRL_EN] && line_pix != 13'h0000
      |=> state_q == ST_DELAY && dly_q >= 17'(DLY40_CYC);
  endproperty
  a_trig_starts_delay: assert property (p_trig_starts_delay) else $error("trigger not taken");

  property p_first_pair;
    @(posedge clk) disable iff (rst) state_q == ST_ALIGN && pclk_rise |-> pix_index == 13'h0000 ##1 line_valid;
  endproperty
  a_first_pair: assert property (p_first_pair) else $error("first pair not sent");

  c_line_done: cover property (@(posedge clk) disable iff (rst) $fell(line_valid));
  c_eight_bit: cover property (@(posedge clk) disable iff (rst) line_valid && depth_q == DEPTH_8);
  c_fast_bin: cover property (@(posedge clk) disable iff (rst)
    state_q == ST_DELAY && ctrl_q[CTRL_FAST] && ctrl_q[CTRL_BIN]);

endmodule : ttlp_out

`default_nettype wire

// *** ttlp_grabber_model.sv ***
// Frame grabber model capturing words from transmitter X
`timescale 1ns/1ps
`default_nettype none

module ttlp_grabber_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] port_a,
  input wire logic [7:0] port_b,
  input wire logic [7:0] port_c,
  input wire logic line_valid,
  input wire logic data_valid,
  input wire logic tx_strobe,
  output var int n_words,
  output var int n_split
);
  logic lv_q;
  logic stb_q;
  logic [23:0] word_q [0:2047];

  // ==========================================================
  // Capture
  // Word taken mid-period on the strobe fall, only while both flags are high
  always_ff @(posedge clk) begin
    lv_q <= line_valid;
    stb_q <= tx_strobe;
    if (rst) begin
      n_words <= 0;
      n_split <= 0;
    end else begin
      if (line_valid !== data_valid) begin
        n_split <= n_split + 1;
      end
      if (line_valid && !lv_q) begin
        n_words <= 0;
      end else if (stb_q && !tx_strobe && line_valid && data_valid && n_words < 2048) begin
        word_q[n_words] <= {port_c, port_b, port_a};
        n_words <= n_words + 1;
      end
    end
  end
endmodule : ttlp_grabber_model
`default_nettype wire

// *** test_ttlp_out.sv ***
// Self-checking testbench of the two-tap line pixel output block
`timescale 1ns/1ps
`default_nettype none

module test_ttlp_out;
  import ttlp_pkg::*;
  localparam int ROWS = 13;
  localparam int MID = 10;
  logic clk = 1'h0, rst = 1'h1, pix_clk = 1'h0, line_trig = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pix_take;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [11:0] pix_odd, pix_even;
  logic [12:0] pix_index;
  logic [7:0] port_a, port_b, port_c;
  logic line_valid, data_valid, frame_valid, spare, tx_strobe, pix_clk_fast;
  int miscompares = 0, n_compared = 0, cycles = 0, n_words, n_split;
  // Per row: control word, pixels per line, delay in cycles
  logic [31:0] t_ctrl [ROWS] = '{32'h342, 32'h341, 32'h340, 32'h346, 32'h336, 32'h34A, 32'h33A,
    32'h32E, 32'h33E, 32'h302, 32'h342, 32'h246, 32'h2C6};
  int t_n [ROWS] = '{6, 6, 5, 6, 6, 6, 6, 6, 6, 6, 40, 1024, 2048};
  int t_d [ROWS] = '{27, 27, 27, 33, 33, 29, 29, 95, 99, 37, 27, 33, 33};

  // ==========================================================
  // Clocks, sensor pattern and instances
  always #50 clk = ~clk;
  initial begin
    #137;
    forever #400 pix_clk = ~pix_clk;
  end
  // Sensor answers the pair index at once
  assign pix_odd = pix_index[11:0] ^ 12'hA5C;
  assign pix_even = pix_index[11:0] ^ 12'h3E1;

  ttlp_out uut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pix_clk, .line_trig, .pix_odd,
    .pix_even, .pix_take, .pix_index, .port_a, .port_b, .port_c, .line_valid, .data_valid, .frame_valid,
    .spare, .tx_strobe, .pix_clk_fast);

  ttlp_grabber_model g (.clk, .rst, .port_a, .port_b, .port_c, .line_valid, .data_valid, .tx_strobe,
    .n_words, .n_split);

  // ==========================================================
  // Shared tasks
  task automatic test_done();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Handshakes judged mid-cycle, released after the taking edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    b = 1'h0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!b) begin
      @(negedge clk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'h0;
      if (w) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, rv;
    rv = 1'h0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!rv) begin
      @(negedge clk);
      ar = s_axi_arvalid & s_axi_arready;
      rv = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ar) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    @(posedge clk);
  endtask : rd

  // Expected transmitter word {C, B, A} for one pixel pair
  function automatic logic [23:0] fmt(input logic [1:0] dp, input logic [11:0] o, input logic [11:0] e);
    logic [9:0] o10, e10;
    o10 = o[11:2];
    e10 = e[11:2];
    if (dp == 2'h2) return {e[7:0], e[11:8], o[11:8], o[7:0]};
    if (dp == 2'h1) return {e10[7:0], 2'h0, e10[9:8], 2'h0, o10[9:8], o10[7:0]};
    return {8'h00, e[11:4], o[11:4]};
  endfunction : fmt

  // One triggered line: delay, flags, word count and every word
  task automatic run_line(input int k);
    logic [31:0] c;
    logic [1:0] r;
    logic [31:0] s;
    logic [23:0] w;
    int d, i;
    c = t_ctrl[k];
    wr(OFS_REGION, c[8] ? 32'(t_n[k]) : 32'h6, r);
    wr(OFS_CTRL, c, r);
    chk("pix_clk_fast", 32'(c[3]), 32'(pix_clk_fast));
    line_trig <= 1'h1;
    d = 0;
    while (!line_valid && d < 400) begin
      @(negedge clk);
      d++;
    end
    // Trigger sync, decode and pixel clock alignment add five to twelve cycles
    chk("delay_min", 32'h1, 32'(d >= t_d[k] + 5));
    chk("delay_max", 32'h1, 32'(d <= t_d[k] + 12));
    chk("frame_valid", 32'h0, 32'(frame_valid));
    chk("spare", 32'h0, 32'(spare));
    @(posedge clk);
    line_trig <= 1'h0;
    if (k == MID) begin
      wr(OFS_CTRL, c & 32'hFFFFFFFC, r);
      line_trig <= 1'h1;
      repeat (3) @(posedge clk);
      line_trig <= 1'h0;
      rd(OFS_STATUS, s, r);
      chk("status_mid", 32'({c[1:0], 2'h3}), 32'(s[3:0]));
    end
    while (line_valid) @(negedge clk);
    repeat (4) @(posedge clk);
    chk("word_count", 32'((t_n[k] + 1) / 2), 32'(n_words));
    for (i = 0; i < n_words && i < 2048; i++) begin
      w = fmt(c[1:0], 12'(2 * i) ^ 12'hA5C, 12'(2 * i) ^ 12'h3E1);
      chk("word", 32'(w), 32'(g.word_q[i]));
    end
  endtask : run_line

  // ==========================================================
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      test_done();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int k;
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    @(negedge clk);
    chk("line_valid_idle", 32'h0, 32'(line_valid));
    chk("data_valid_idle", 32'h0, 32'(data_valid));
    @(posedge clk);
    rd(OFS_CTRL, d, r);
    chk("ctrl_reset", 32'(CTRL_RST), d);
    rd(OFS_REGION, d, r);
    chk("region_reset", 32'(REGION_RST), d);
    rd(4'h2, d, r);
    chk("unmapped_resp", 32'(RESP_SLVERR), 32'(r));
    chk("unmapped_data", 32'h0, d);
    wr(OFS_STATUS, 32'hFFFF, r);
    chk("status_write_resp", 32'(RESP_SLVERR), 32'(r));
    wr(OFS_EXPO, 32'hA, r);
    chk("write_resp", 32'(RESP_OKAY), 32'(r));
    rd(OFS_EXPO, d, r);
    chk("expo_readback", 32'hA, d);
    chk("read_resp", 32'(RESP_OKAY), 32'(r));
    for (k = 0; k < ROWS; k++) begin
      run_line(k);
    end
    rd(OFS_STATUS, d, r);
    chk("lines_sent", 32'(ROWS), 32'(d[31:16]));
    chk("status_idle", 32'h0, 32'(d[1:0]));
    chk("flag_split", 32'h0, 32'(n_split));
    test_done();
  end
endmodule : test_ttlp_out
`default_nettype wire
